// ### pkg/ssq_pkg.sv
package ssq_pkg;

  // ------------------------------------------------------------------
  // Register map (APB byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_PROG_BASE = 8'h00;
  localparam logic [7:0] ADDR_PROG_LAST = 8'h5C;
  localparam logic [7:0] ADDR_CTRL = 8'h80;
  localparam logic [7:0] ADDR_STAT = 8'h84;
  localparam logic [7:0] ADDR_X = 8'h88;
  localparam logic [7:0] ADDR_Y = 8'h8C;
  localparam logic [7:0] ADDR_Z = 8'h90;
  localparam logic [7:0] ADDR_FLAGS = 8'h94;

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int CTRL_HOST_BIT = 0;
  localparam int CTRL_START_BIT = 1;
  localparam int CTRL_STOP_BIT = 2;
  localparam int STAT_RUN_BIT = 5;
  localparam int FLAG_STOP_BIT = 0;
  localparam int FLAG_WAIT_BIT = 1;
  localparam int FLAG_SWI_BIT = 2;
  localparam logic [7:0] RST_SCRATCH = 8'h00;
  localparam logic [7:0] RST_INSTR = 8'hD0;

  // ------------------------------------------------------------------
  // Program memory and opcodes
  // ------------------------------------------------------------------
  localparam int PROG_DEPTH = 24;
  localparam logic [4:0] PC_LAST = 5'd23;
  localparam logic [7:0] OP_X_UP = 8'hC0;
  localparam logic [7:0] OP_Y_UP = 8'hC1;
  localparam logic [7:0] OP_Z_UP = 8'hC2;
  localparam logic [7:0] OP_X_DOWN = 8'hC3;
  localparam logic [7:0] OP_Y_DOWN = 8'hC4;
  localparam logic [7:0] OP_Z_DOWN = 8'hC5;
  localparam logic [7:0] OP_AWAIT_ONE = 8'hB8;
  localparam logic [7:0] OP_AWAIT_TWO = 8'hB9;
  localparam logic [7:0] OP_SWI = 8'hBA;
  localparam logic [7:0] OP_LABEL = 8'hBB;
  localparam logic [7:0] OP_TIMED_WAIT = 8'hBC;
  localparam logic [7:0] OP_RAND_LOAD = 8'hBD;
  localparam logic [7:0] OP_CAPTURE = 8'hBE;
  localparam logic [7:0] OP_STOP = 8'hD2;
  localparam logic [4:0] OPC_SATY = 5'b11001;
  localparam logic [2:0] OPC_WAIT = 3'b100;
  localparam logic [3:0] OPC_REPEAT = 4'b1010;
  localparam logic [5:0] WAIT_FULL = 6'd32;

  typedef enum logic [1:0] {
    SSQ_IDLE,
    SSQ_FETCH,
    SSQ_WAIT
  } ssq_state_t;

endpackage : ssq_pkg

// ### verilog/ssq_exec.sv
`timescale 1ns/1ps

// Summary of operation
// [RULE_01] Down opcodes decrement x, y or z, wrapping zero to all ones.
// [RULE_02] Up opcodes increment x, y or z, wrapping all ones to zero.
// [RULE_03] Saturating y increment sets y to min(y plus one, M).
// [RULE_04] Random load puts y low random bits in x; y 0 or >7 gives 8.
// [RULE_05] Back-to-back random loads may reuse the same random value.
// [RULE_06] Software interrupt opcode raises the program interrupt flag.
// [RULE_07] Timed wait decrements x per overflow, advances at zero, flags done.
// [RULE_08] Timed wait with x already zero continues at once; live x governs.
// [RULE_09] Fixed wait stalls for W overflows, W zero meaning 32, then flags.
// [RULE_10] Capture opcode pulses the timer compare set output.
// [RULE_11] Event one wait holds the counter until event one is high.
// [RULE_12] Event two wait holds the counter until event two is high.
// [RULE_13] Label stores pc plus one, or pc itself in the last slot.
// [RULE_14] Only one loop start is held; a new label replaces the old.
// [RULE_15] Repeat jumps to loop start when C xor N and a label is set.
// [RULE_16] Condition codes: clear, frame, host bit, pc 23, x0, y0, z0, rssi.
// [RULE_17] Skip adds S plus one to pc when C xor N, else one.
// [RULE_18] Skip with S zero re-executes itself while its condition holds.
// [RULE_19] Skipping past the last loaded instruction stops execution.
// [RULE_20] Any stop, end of memory or timeout zero sets the stop flag.
// [RULE_21] Undefined opcodes execute as no-operation and advance.
// [RULE_22] Program memory holds 24 bytes, addresses 0 to 23, host readable.
module ssq_exec (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Radio and timer status
  input wire logic channel_clear,
  input wire logic frame_active,
  input wire logic signal_strength_valid,
  input wire logic [7:0] random_source_output,
  input wire logic timer_overflow,
  input wire logic timer_event_one,
  input wire logic timer_event_two,
  input wire logic timeout_zero,
  // Sequencer outputs
  output logic timer_compare_set_pulse,
  output logic program_irq_flag,
  output logic wait_done_flag,
  output logic stop_flag,
  output logic running
);
  import ssq_pkg::*;

  typedef struct packed {
    ssq_state_t state;
    logic [PROG_DEPTH-1:0][7:0] mem;
    logic [4:0] pc;
    logic [4:0] prog_len;
    logic [4:0] loop_start;
    logic loop_valid;
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] z;
    logic [5:0] wait_cnt;
    logic host_bit;
    logic cmp_pulse;
    logic f_swi;
    logic f_wait;
    logic f_stop;
    logic [31:0] rdata;
  } ssq_regs_t;

  ssq_regs_t r;
  ssq_regs_t next_r;

  // ------------------------------------------------------------------
  // Condition evaluation
  // ------------------------------------------------------------------
  function automatic logic ssq_cond(input logic [3:0] nc,
                                    input ssq_regs_t s);
    logic c;
    c = 1'b0;
    case (nc[2:0])
      3'd0: c = channel_clear; // RULE_16
      3'd1: c = frame_active;
      3'd2: c = s.host_bit;
      3'd3: c = (s.pc == PC_LAST);
      3'd4: c = (s.x == 8'h00);
      3'd5: c = (s.y == 8'h00);
      3'd6: c = (s.z == 8'h00);
      default: c = signal_strength_valid;
    endcase
    return c ^ nc[3];
  endfunction : ssq_cond

  logic acc;
  logic [7:0] op;
  logic [5:0] skip_tgt;
  logic [7:0] rmask;
  logic [7:0] y_inc;

  assign acc = psel && penable;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = r.rdata;
  assign timer_compare_set_pulse = r.cmp_pulse;
  assign program_irq_flag = r.f_swi;
  assign wait_done_flag = r.f_wait;
  assign stop_flag = r.f_stop;
  assign running = (r.state != SSQ_IDLE);
  assign op = r.mem[r.pc];

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.cmp_pulse = 1'b0;
    skip_tgt = {1'b0, r.pc} + {2'b00, op[6:4]} + 6'd1; // RULE_17
    y_inc = r.y + 8'h01;
    rmask = (r.y == 8'h00 || r.y > 8'h07) ? 8'hFF : // RULE_04
            8'((9'h001 << r.y[2:0]) - 9'h001);

    // Software access; hardware events below win over clears.
    if (acc && pwrite) begin
      case (paddr)
        ADDR_CTRL: begin
          next_r.host_bit = pwdata[CTRL_HOST_BIT];
          if (pwdata[CTRL_START_BIT] && r.prog_len != 5'd0) begin
            next_r.state = SSQ_FETCH;
            next_r.pc = 5'd0;
          end
          if (pwdata[CTRL_STOP_BIT] && r.state != SSQ_IDLE) begin
            next_r.state = SSQ_IDLE;
            next_r.loop_valid = 1'b0;
            next_r.f_stop = 1'b1; // RULE_20
          end
        end
        ADDR_X: next_r.x = pwdata[7:0];
        ADDR_Y: next_r.y = pwdata[7:0];
        ADDR_Z: next_r.z = pwdata[7:0];
        ADDR_FLAGS: begin
          if (pwdata[FLAG_STOP_BIT]) next_r.f_stop = 1'b0;
          if (pwdata[FLAG_WAIT_BIT]) next_r.f_wait = 1'b0;
          if (pwdata[FLAG_SWI_BIT]) next_r.f_swi = 1'b0;
        end
        default: begin
          if (paddr <= ADDR_PROG_LAST && paddr[1:0] == 2'b00 &&
              r.state == SSQ_IDLE && r.prog_len < 5'(PROG_DEPTH)) begin
            next_r.mem[r.prog_len] = pwdata[7:0];
            next_r.prog_len = r.prog_len + 5'd1;
          end
        end
      endcase
    end

    case (r.state)
      SSQ_FETCH: begin
        next_r.pc = r.pc + 5'd1;
        if (op[7:3] == OPC_SATY) begin
          next_r.y = (r.y < {5'd0, op[2:0]}) ? y_inc :
                     {5'd0, op[2:0]}; // RULE_03
        end else if (op[7:5] == OPC_WAIT) begin
          next_r.wait_cnt = (op[4:0] == 5'd0) ? WAIT_FULL :
                            {1'b0, op[4:0]}; // RULE_09
          next_r.pc = r.pc;
          next_r.state = SSQ_WAIT;
        end else if (op[7:4] == OPC_REPEAT) begin
          if (ssq_cond(op[3:0], r) && r.loop_valid)
            next_r.pc = r.loop_start; // RULE_15
        end else if (op[7] == 1'b0) begin
          if (ssq_cond(op[3:0], r)) begin
            if (op[6:4] == 3'd0) begin
              next_r.pc = r.pc; // RULE_18
            end else if (skip_tgt >= {1'b0, r.prog_len}) begin
              next_r.state = SSQ_IDLE; // RULE_19
              next_r.loop_valid = 1'b0;
              next_r.f_stop = 1'b1; // RULE_20
            end else begin
              next_r.pc = skip_tgt[4:0]; // RULE_17
            end
          end
        end else begin
          case (op)
            OP_X_UP: next_r.x = r.x + 8'h01; // RULE_02
            OP_Y_UP: next_r.y = r.y + 8'h01; // RULE_02
            OP_Z_UP: next_r.z = r.z + 8'h01; // RULE_02
            OP_X_DOWN: next_r.x = r.x - 8'h01; // RULE_01
            OP_Y_DOWN: next_r.y = r.y - 8'h01; // RULE_01
            OP_Z_DOWN: next_r.z = r.z - 8'h01; // RULE_01
            // The random input is sampled as is; no refresh is forced.
            OP_RAND_LOAD: next_r.x = random_source_output & rmask; // RULE_05
            OP_SWI: next_r.f_swi = 1'b1; // RULE_06
            OP_CAPTURE: next_r.cmp_pulse = 1'b1; // RULE_10
            OP_LABEL: begin
              next_r.loop_start = (r.pc == PC_LAST) ? r.pc :
                                  r.pc + 5'd1; // RULE_13
              next_r.loop_valid = 1'b1; // RULE_14
            end
            OP_TIMED_WAIT: begin
              if (r.x != 8'h00) begin // RULE_08
                next_r.pc = r.pc;
                next_r.state = SSQ_WAIT;
              end else begin
                next_r.f_wait = 1'b1;
              end
            end
            OP_AWAIT_ONE, OP_AWAIT_TWO: begin
              next_r.pc = r.pc;
              next_r.state = SSQ_WAIT;
            end
            OP_STOP: begin
              next_r.state = SSQ_IDLE;
              next_r.loop_valid = 1'b0;
              next_r.f_stop = 1'b1; // RULE_20
            end
            default: ; // RULE_21
          endcase
        end
        if (next_r.state == SSQ_FETCH && r.pc == r.prog_len - 5'd1 &&
            next_r.pc == r.pc + 5'd1) begin
          next_r.state = SSQ_IDLE;
          next_r.loop_valid = 1'b0;
          next_r.f_stop = 1'b1; // RULE_20
        end
      end
      SSQ_WAIT: begin
        if (op == OP_AWAIT_ONE) begin
          if (timer_event_one) next_r.state = SSQ_FETCH; // RULE_11
        end else if (op == OP_AWAIT_TWO) begin
          if (timer_event_two) next_r.state = SSQ_FETCH; // RULE_12
        end else if (op == OP_TIMED_WAIT) begin
          if (r.x == 8'h00) begin // RULE_07
            next_r.state = SSQ_FETCH;
            next_r.f_wait = 1'b1;
          end else if (timer_overflow) begin
            next_r.x = r.x - 8'h01;
          end
        end else if (r.wait_cnt == 6'd0) begin
          next_r.state = SSQ_FETCH;
          next_r.f_wait = 1'b1; // RULE_09
        end else if (timer_overflow) begin
          next_r.wait_cnt = r.wait_cnt - 6'd1;
        end
        if (next_r.state == SSQ_FETCH) begin
          if (r.pc == r.prog_len - 5'd1) begin
            next_r.state = SSQ_IDLE;
            next_r.loop_valid = 1'b0;
            next_r.f_stop = 1'b1;
          end else begin
            next_r.pc = r.pc + 5'd1;
          end
        end
      end
      default: ;
    endcase

    if (r.state != SSQ_IDLE && timeout_zero) begin
      next_r.state = SSQ_IDLE;
      next_r.loop_valid = 1'b0;
      next_r.f_stop = 1'b1; // RULE_20
    end

    // Read data for the next access phase.
    next_r.rdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        ADDR_CTRL: next_r.rdata = {31'd0, r.host_bit};
        ADDR_STAT: next_r.rdata = {26'd0, running, r.pc};
        ADDR_X: next_r.rdata = {24'd0, r.x};
        ADDR_Y: next_r.rdata = {24'd0, r.y};
        ADDR_Z: next_r.rdata = {24'd0, r.z};
        ADDR_FLAGS: next_r.rdata = {29'd0, r.f_swi, r.f_wait, r.f_stop};
        default: begin
          if (paddr <= ADDR_PROG_LAST && paddr[1:0] == 2'b00)
            next_r.rdata = {24'd0, r.mem[paddr[6:2]]}; // RULE_22
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
      r.mem <= {PROG_DEPTH{RST_INSTR}};
      r.state <= SSQ_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_fetch(logic [7:0] code);
    r.state == SSQ_FETCH && op == code;
  endsequence

  a_x_decrement: assert property (@(posedge clk) disable iff (!rst_b) // RULE_01
    s_fetch(OP_X_DOWN) ##0 !(acc && pwrite) |=> r.x == $past(r.x) - 8'h01)
    else $error("x decrement wrong");
  a_z_increment: assert property (@(posedge clk) disable iff (!rst_b) // RULE_02
    s_fetch(OP_Z_UP) ##0 !(acc && pwrite) |=> r.z == $past(r.z) + 8'h01)
    else $error("z increment wrong");
  a_sat_limit: assert property (@(posedge clk) disable iff (!rst_b) // RULE_03
    r.state == SSQ_FETCH && op[7:3] == OPC_SATY && !(acc && pwrite)
    |=> r.y <= {5'd0, $past(op[2:0])})
    else $error("saturating y exceeds limit");
  a_swi_flag: assert property (@(posedge clk) disable iff (!rst_b) // RULE_06
    s_fetch(OP_SWI) |=> program_irq_flag)
    else $error("software interrupt not raised");
  a_cmp_pulse: assert property (@(posedge clk) disable iff (!rst_b) // RULE_10
    s_fetch(OP_CAPTURE) |=> timer_compare_set_pulse ##1
    (!timer_compare_set_pulse ||
     $past(r.state == SSQ_FETCH && op == OP_CAPTURE)))
    else $error("compare pulse not one cycle");
  a_event_hold: assert property (@(posedge clk) disable iff (!rst_b) // RULE_11
    r.state == SSQ_WAIT && op == OP_AWAIT_ONE && !timer_event_one &&
    !timeout_zero && !(acc && pwrite) |=> r.state == SSQ_WAIT && $stable(r.pc))
    else $error("event wait released early");
  a_label_store: assert property (@(posedge clk) disable iff (!rst_b) // RULE_13
    s_fetch(OP_LABEL) ##0 (r.pc != PC_LAST && r.pc != r.prog_len - 5'd1 &&
    !timeout_zero && !(acc && pwrite))
    |=> r.loop_valid && r.loop_start == $past(r.pc) + 5'd1)
    else $error("loop start wrong");
  a_wait_done: assert property (@(posedge clk) disable iff (!rst_b) // RULE_07
    r.state == SSQ_WAIT && op == OP_TIMED_WAIT && r.x == 8'h00
    |=> wait_done_flag)
    else $error("timed wait done flag missing");
  a_stop_flag: assert property (@(posedge clk) disable iff (!rst_b) // RULE_20
    s_fetch(OP_STOP) |=> stop_flag && !running)
    else $error("stop did not halt");
  a_skip_hold: assert property (@(posedge clk) disable iff (!rst_b) // RULE_18
    r.state == SSQ_FETCH && op[7:4] == 4'h0 && ssq_cond(op[3:0], r) &&
    !timeout_zero && !(acc && pwrite) |=> $stable(r.pc) && running)
    else $error("busy skip did not hold");

endmodule : ssq_exec

// ### tb/ssq_timer_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------
// MAC timer stand-in
// ------------------------------------------------------------------
module ssq_timer_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Timer outputs
  output logic timer_overflow,
  output logic timer_event_one,
  output logic timer_event_two
);
  logic [7:0] cnt;

  // Overflow is a one-cycle pulse every eight cycles; events come rarely.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 8'h00;
      timer_overflow <= 1'b0;
      timer_event_one <= 1'b0;
      timer_event_two <= 1'b0;
    end else begin
      cnt <= cnt + 8'h01;
      timer_overflow <= (cnt[2:0] == 3'h7);
      timer_event_one <= (cnt[5:0] == 6'h2A);
      timer_event_two <= (cnt[4:0] == 5'h13);
    end
  end
endmodule : ssq_timer_model

// ### tb/strobe_sequencer_instruction_exec_tb.sv
`timescale 1ns/1ps

module strobe_sequencer_instruction_exec_tb;
  import ssq_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic channel_clear = 1'b0;
  logic frame_active = 1'b0;
  logic signal_strength_valid = 1'b0;
  logic [7:0] random_source_output = 8'h00;
  logic timer_overflow;
  logic timer_event_one;
  logic timer_event_two;
  logic timeout_zero = 1'b0;
  logic timer_compare_set_pulse;
  logic program_irq_flag;
  logic wait_done_flag;
  logic stop_flag;
  logic running;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  int ovf_cnt = 0;
  int cap_cnt = 0;
  int ovf0;
  int cap0;
  int cnt;
  int lim;
  integer seed = 32'h48221AF5;
  logic [7:0] prog[$];
  logic [31:0] q, rx, ry, rz, rv;
  logic [7:0] a, b, v;

  ssq_exec uut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .channel_clear(channel_clear),
    .frame_active(frame_active),
    .signal_strength_valid(signal_strength_valid),
    .random_source_output(random_source_output),
    .timer_overflow(timer_overflow), .timer_event_one(timer_event_one),
    .timer_event_two(timer_event_two), .timeout_zero(timeout_zero),
    .timer_compare_set_pulse(timer_compare_set_pulse),
    .program_irq_flag(program_irq_flag), .wait_done_flag(wait_done_flag),
    .stop_flag(stop_flag), .running(running));

  ssq_timer_model partner (.clk(clk), .rst_b(rst_b),
    .timer_overflow(timer_overflow), .timer_event_one(timer_event_one),
    .timer_event_two(timer_event_two));

  always #12.5 clk = ~clk;

  // ------------------------------------------------------------------
  // Monitors and hang guard
  // ------------------------------------------------------------------
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (running === 1'b1 && timer_overflow === 1'b1)
      ovf_cnt <= ovf_cnt + 1;
    if (timer_compare_set_pulse === 1'b1)
      cap_cnt <= cap_cnt + 1;
    if (cycles == 40000) begin
      num_errors = num_errors + 1;
      final_report();
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task final_report;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // ------------------------------------------------------------------
  // Reset, load, start and wait for the program to stop
  // ------------------------------------------------------------------
  task run(input logic [7:0] x0, y0, z0, input logic h, hold);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b1, ADDR_X, {24'h0, x0});
    apb(1'b1, ADDR_Y, {24'h0, y0});
    apb(1'b1, ADDR_Z, {24'h0, z0});
    foreach (prog[i]) apb(1'b1, ADDR_PROG_BASE, {24'h0, prog[i]});
    apb(1'b0, 8'(prog.size() * 4 - 4), 32'h0);
    check(q, {24'h0, prog[prog.size() - 1]});
    apb(1'b0, ADDR_PROG_LAST, 32'h0);
    check(q, {24'h0, RST_INSTR});
    check(pslverr, 1'b0);
    ovf0 = ovf_cnt;
    cap0 = cap_cnt;
    apb(1'b1, ADDR_CTRL, {30'h0, 1'b1, h});
    if (hold) begin
      repeat (20) @(posedge clk);
      check(running, 1);
      apb(1'b1, ADDR_CTRL, 32'h0);
    end
    repeat (2) @(posedge clk);
    while (running === 1'b1) @(posedge clk);
    apb(1'b0, ADDR_X, 32'h0);
    rx = q;
    apb(1'b0, ADDR_Y, 32'h0);
    ry = q;
    apb(1'b0, ADDR_Z, 32'h0);
    rz = q;
  endtask : run

  initial begin
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
      prog = '{8'hC0, 8'hC3, 8'hC3, 8'hC4, 8'hC2, 8'hC2, 8'hC5};
      run(a, 8'h00, 8'hFF, 1'b0, 1'b0);
      check(rx, {24'h0, a - 8'h01});
      check(ry, 32'hFF);
      check(rz, 32'h0);
    end
    for (int m = 0; m < 8; m++) begin
      a = 8'($random(seed)) & 8'h07;
      prog = '{8'hC8 | 8'(m)};
      run(8'h00, a, 8'h00, 1'b0, 1'b0);
      check(ry, (a + 1 < m) ? a + 1 : m);
    end
    for (int i = 0; i < 10; i++) begin
      b = 8'($random(seed));
      random_source_output <= b;
      prog = '{8'hBD, 8'hBD};
      run(8'h00, 8'(i), 8'h00, 1'b0, 1'b0);
      v = (i == 0 || i > 7) ? b : b & ((8'h01 << i) - 8'h01);
      check(rx, {24'h0, v});
    end
    prog = '{8'hBA, 8'hBE, 8'hF0, 8'hB8, 8'hB9, 8'hC0, 8'hD2, 8'hC0};
    run(8'h10, 8'h00, 8'h00, 1'b0, 1'b0);
    check(rx, 32'h11);
    check(program_irq_flag, 1);
    check(cap_cnt - cap0, 1);
    check(stop_flag, 1);
    prog = '{8'hBC, 8'hC1};
    run(8'h03, 8'h00, 8'h00, 1'b0, 1'b0);
    check(rx, 32'h0);
    check(ovf_cnt - ovf0 >= 3, 1);
    check(wait_done_flag, 1);
    run(8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
    check(ry, 32'h1);
    check(wait_done_flag, 1);
    for (int w = 0; w < 3; w += 2) begin
      prog = '{8'h80 | 8'(w)};
      run(8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
      cnt = ovf_cnt - ovf0;
      lim = (w == 0) ? 32 : w;
      check(cnt >= lim && cnt <= lim + 1, 1);
      check(wait_done_flag, 1);
    end
    prog = '{8'hBB, 8'hC2, 8'hBB, 8'hC4, 8'hC0, 8'hAD};
    run(8'h00, 8'h02, 8'h00, 1'b0, 1'b0);
    check(rx, 32'h2);
    check(ry, 32'h0);
    check(rz, 32'h1);
    prog = '{8'hA4, 8'hC0};
    run(8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
    check(rx, 32'h1);
    for (int c = 0; c < 8; c++) begin
      rv = $random(seed);
      channel_clear <= rv[3];
      frame_active <= rv[4];
      signal_strength_valid <= rv[5];
      a = rv[1] ? 8'h00 : rv[23:16];
      v = {rv[5], rv[2] ? 1'b1 : rv[31:24] == 8'h00, a == 8'h00,
        rv[0] ? 1'b1 : rv[15:8] == 8'h00, 1'b0, rv[6], rv[4], rv[3]};
      prog = '{8'h10 | {4'h0, rv[7], 3'(c)}, 8'hC1};
      run(rv[0] ? 8'h00 : rv[15:8], a, rv[2] ? 8'h00 : rv[31:24], rv[6], 1'b0);
      check(ry, {24'h0, a + {7'h0, ~(v[c] ^ rv[7])}});
    end
    prog = '{8'h72, 8'hC0};
    run(8'h00, 8'h00, 8'h00, 1'b1, 1'b0);
    check(rx, 32'h0);
    check(stop_flag, 1);
    prog = '{8'h02, 8'hC0};
    run(8'h00, 8'h00, 8'h00, 1'b1, 1'b1);
    check(rx, 32'h1);
    timeout_zero <= 1'b1;
    prog = '{8'h80, 8'hC0};
    run(8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
    timeout_zero <= 1'b0;
    check(rx, 32'h0);
    check(stop_flag, 1);
    final_report();
  end
endmodule : strobe_sequencer_instruction_exec_tb
